/* rtl/radio_status_address_regs.sv */
`timescale 1ns/1ps
`include "radio_regs_map.svh"

module radio_status_address_regs (
  input  wire logic                          mclk_i,
  input  wire logic                          rst_n_i,
  input  wire logic                          ce_i,
  input  wire logic                          sck_i,
  input  wire logic                          csn_i,
  input  wire logic                          mosi_i,
  output logic                               miso_o,
  output logic                               miso_oe_o,
  input  wire radio_regs_pkg::radio_events_t events_i,
  input  wire logic                          auto_ack_en_i,
  input  wire logic [2:0]                    rx_head_pipe_i,
  input  wire logic                          rx_empty_i,
  input  wire logic                          tx_full_i,
  input  wire logic                          power_detect_i,
  input  wire logic [1:0]                    address_width_field_i,
  output logic                               comm_blocked_o,
  output logic                               channel_write_o,
  output logic [39:0]                        pipe0_addr_o,
  output logic [39:0]                        pipe1_addr_o,
  output logic [39:0]                        pipe2_addr_o,
  output logic [39:0]                        pipe3_addr_o
);

  radio_regs_pkg::status_t status;

  logic        frame_start;
  logic        byte_done;
  logic [7:0]  rx_byte;
  logic [7:0]  tx_byte;

  logic        rx_ready_q;
  logic        tx_done_q;
  logic        retx_limit_q;
  logic [2:0]  pipe_q;
  logic        tx_full_q;
  logic        power_detect_q;

  logic [7:0]  cmd_q;
  logic        first_q;
  logic [2:0]  idx_q;

  logic [39:0] pipe0_q;
  logic [39:0] pipe1_q;
  logic [7:0]  pipe2_q;
  logic [7:0]  pipe3_q;

  logic [3:0]  lost_cnt;
  logic [3:0]  retx_cnt;

  logic        wr_data;
  logic [4:0]  wr_addr;
  logic        wr_in_width;
  logic        clr_rx_ready;
  logic        clr_tx_done;
  logic        clr_retx_limit;
  logic        tx_done_set;
  logic [2:0]  next_idx;
  logic [4:0]  rd_addr;

  // Width code to byte count; illegal 00 falls back to the full width
  function automatic logic [2:0] width_bytes(input logic [1:0] aw);
    unique case (aw)
      `AW_3_BYTES: width_bytes = 3'h3;
      `AW_4_BYTES: width_bytes = 3'h4;
      `AW_5_BYTES: width_bytes = `ADDR_MAX_BYTES;
      default:     width_bytes = `ADDR_MAX_BYTES;
    endcase
  endfunction

  function automatic logic [39:0] width_mask(input logic [1:0] aw);
    unique case (aw)
      `AW_3_BYTES: width_mask = 40'h0000FFFFFF;
      `AW_4_BYTES: width_mask = 40'h00FFFFFFFF;
      default:     width_mask = 40'hFFFFFFFFFF;
    endcase
  endfunction

  // Fixed byte lanes, so no select can reach past bit 39
  function automatic logic [7:0] addr_byte(input logic [39:0] a, input logic [2:0] n);
    unique case (n)
      3'h0:    addr_byte = a[7:0];
      3'h1:    addr_byte = a[15:8];
      3'h2:    addr_byte = a[23:16];
      3'h3:    addr_byte = a[31:24];
      3'h4:    addr_byte = a[39:32];
      default: addr_byte = 8'h00;
    endcase
  endfunction

  spi_shift_slave u_spi (
    .mclk_i        (mclk_i),
    .rst_n_i       (rst_n_i),
    .ce_i          (ce_i),
    .sck_i         (sck_i),
    .csn_i         (csn_i),
    .mosi_i        (mosi_i),
    .status_i      (status),
    .tx_byte_i     (tx_byte),
    .frame_start_o (frame_start),
    .byte_done_o   (byte_done),
    .rx_byte_o     (rx_byte),
    .miso_o        (miso_o),
    .miso_oe_o     (miso_oe_o)
  );

  // Lost counter clears from the registered channel strobe, one cycle late
  tx_observe_counters #(
    .CNT_W (4)
  ) u_counters (
    .mclk_i        (mclk_i),
    .rst_n_i       (rst_n_i),
    .ce_i          (ce_i),
    .packet_lost_i (events_i.packet_lost),
    .lost_clear_i  (channel_write_o),
    .retransmit_i  (events_i.retransmit),
    .new_packet_i  (events_i.new_packet),
    .lost_cnt_o    (lost_cnt),
    .retx_cnt_o    (retx_cnt)
  );

  always_comb begin
    status.reserved   = 1'b0;
    status.rx_ready   = rx_ready_q;
    status.tx_done    = tx_done_q;
    status.retx_limit = retx_limit_q;
    status.pipe       = pipe_q;
    status.tx_full    = tx_full_q;
  end

  // Command decode: byte after the command is a data byte
  assign wr_data     = byte_done && !first_q && cmd_q[7:5] == `CMD_OP_WRITE;
  assign wr_addr     = cmd_q[4:0];
  assign wr_in_width = idx_q < width_bytes(address_width_field_i);

  // Only a 1 clears; a 0 leaves the flag alone
  assign clr_rx_ready   = wr_data && wr_addr == `REG_STATUS && rx_byte[`STAT_RX_READY_BIT];
  assign clr_tx_done    = wr_data && wr_addr == `REG_STATUS && rx_byte[`STAT_TX_DONE_BIT];
  assign clr_retx_limit = wr_data && wr_addr == `REG_STATUS && rx_byte[`STAT_RETX_LIMIT_BIT];

  // With auto-ack the ack, not the send, marks completion
  assign tx_done_set = auto_ack_en_i ? events_i.ack_received : events_i.tx_sent;

  // Set beats clear when both land together
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rx_ready_q <= 1'b0;
    end else if (ce_i) begin
      if (events_i.rx_stored) begin
        rx_ready_q <= 1'b1;
      end else if (clr_rx_ready) begin
        rx_ready_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tx_done_q <= 1'b0;
    end else if (ce_i) begin
      if (tx_done_set) begin
        tx_done_q <= 1'b1;
      end else if (clr_tx_done) begin
        tx_done_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      retx_limit_q   <= 1'b0;
      comm_blocked_o <= 1'b0;
    end else if (ce_i) begin
      if (events_i.retx_limit_hit) begin
        retx_limit_q <= 1'b1;
      end else if (clr_retx_limit) begin
        retx_limit_q <= 1'b0;
      end
      comm_blocked_o <= retx_limit_q;
    end
  end

  // Read-only fields track the queues and the power detector; host writes never reach them
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pipe_q         <= `PIPE_QUEUE_EMPTY;
      tx_full_q      <= 1'b0;
      power_detect_q <= 1'b0;
    end else if (ce_i) begin
      pipe_q         <= rx_empty_i ? `PIPE_QUEUE_EMPTY : rx_head_pipe_i;
      tx_full_q      <= tx_full_i;
      power_detect_q <= power_detect_i;
    end
  end

  // Frame tracking: first byte is the command, then a byte index
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cmd_q   <= 8'h00;
      first_q <= 1'b1;
      idx_q   <= 3'h0;
    end else if (ce_i) begin
      if (frame_start) begin
        first_q <= 1'b1;
        idx_q   <= 3'h0;
      end else if (byte_done) begin
        if (first_q) begin
          cmd_q   <= rx_byte;
          first_q <= 1'b0;
        end else if (idx_q != `ADDR_MAX_BYTES) begin
          idx_q <= idx_q + 3'h1;
        end
      end
    end
  end

  // One pulse for each data byte written to the channel register
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      channel_write_o <= 1'b0;
    end else if (ce_i) begin
      channel_write_o <= wr_data && wr_addr == `REG_CHANNEL_SELECT;
    end
  end

  // Address bytes arrive low byte first; extra bytes are dropped
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pipe0_q <= `PIPE0_ADDR_RESET;
      pipe1_q <= `PIPE1_ADDR_RESET;
    end else if (ce_i && wr_data && wr_in_width) begin
      if (wr_addr == `REG_PIPE0_ADDR) begin
        pipe0_q[{idx_q, 3'h0} +: 8] <= rx_byte;
      end
      if (wr_addr == `REG_PIPE1_ADDR) begin
        pipe1_q[{idx_q, 3'h0} +: 8] <= rx_byte;
      end
    end
  end

  // Only the first data byte of a frame lands; later bytes are dropped
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pipe2_q <= `PIPE2_LOW_RESET;
      pipe3_q <= `PIPE3_LOW_RESET;
    end else if (ce_i && wr_data && idx_q == 3'h0) begin
      if (wr_addr == `REG_PIPE2_LOW) begin
        pipe2_q <= rx_byte;
      end
      if (wr_addr == `REG_PIPE3_LOW) begin
        pipe3_q <= rx_byte;
      end
    end
  end

  // Effective addresses trimmed to the configured width
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pipe0_addr_o <= 40'h0000000000;
      pipe1_addr_o <= 40'h0000000000;
      pipe2_addr_o <= 40'h0000000000;
      pipe3_addr_o <= 40'h0000000000;
    end else if (ce_i) begin
      pipe0_addr_o <= pipe0_q & width_mask(address_width_field_i);
      pipe1_addr_o <= pipe1_q & width_mask(address_width_field_i);
      pipe2_addr_o <= {pipe1_q[39:8], pipe2_q} & width_mask(address_width_field_i);
      pipe3_addr_o <= {pipe1_q[39:8], pipe3_q} & width_mask(address_width_field_i);
    end
  end

  // Next read byte; the command byte itself selects register and index 0
  assign next_idx = first_q ? 3'h0 : idx_q + 3'h1;
  assign rd_addr  = first_q ? rx_byte[4:0] : cmd_q[4:0];

  always_comb begin
    unique case (rd_addr)
      `REG_STATUS:       tx_byte = status;
      `REG_OBSERVE:      tx_byte = {lost_cnt, retx_cnt};
      `REG_POWER_DETECT: tx_byte = {7'h00, power_detect_q};
      `REG_PIPE0_ADDR:   tx_byte = addr_byte(pipe0_q, next_idx);
      `REG_PIPE1_ADDR:   tx_byte = addr_byte(pipe1_q, next_idx);
      `REG_PIPE2_LOW:    tx_byte = (next_idx == 3'h0) ? pipe2_q : 8'h00;
      `REG_PIPE3_LOW:    tx_byte = (next_idx == 3'h0) ? pipe3_q : 8'h00;
      default:           tx_byte = 8'h00;
    endcase
  end

endmodule // radio_status_address_regs

/* rtl/radio_regs_map.svh */
`ifndef RADIO_REGS_MAP_SVH
`define RADIO_REGS_MAP_SVH

`define REG_CHANNEL_SELECT  5'h05
`define REG_STATUS          5'h07
`define REG_OBSERVE         5'h08
`define REG_POWER_DETECT    5'h09
`define REG_PIPE0_ADDR      5'h0A
`define REG_PIPE1_ADDR      5'h0B
`define REG_PIPE2_LOW       5'h0C
`define REG_PIPE3_LOW       5'h0D

`define CMD_OP_READ         3'h0
`define CMD_OP_WRITE        3'h1

`define STAT_RX_READY_BIT   6
`define STAT_TX_DONE_BIT    5
`define STAT_RETX_LIMIT_BIT 4

`define PIPE_QUEUE_EMPTY    3'h7
`define PIPE0_ADDR_RESET    40'hE7E7E7E7E7
`define PIPE1_ADDR_RESET    40'hC2C2C2C2C2
`define PIPE2_LOW_RESET     8'hC3
`define PIPE3_LOW_RESET     8'hC4

`define AW_3_BYTES          2'h1
`define AW_4_BYTES          2'h2
`define AW_5_BYTES          2'h3

`define ADDR_MAX_BYTES      3'h5
`define SPI_LAST_BIT        3'h7

`endif

/* rtl/radio_regs_pkg.sv */
package radio_regs_pkg;

  typedef struct packed {
    logic       reserved;
    logic       rx_ready;
    logic       tx_done;
    logic       retx_limit;
    logic [2:0] pipe;
    logic       tx_full;
  } status_t;

  typedef struct packed {
    logic rx_stored;
    logic tx_sent;
    logic ack_received;
    logic retx_limit_hit;
    logic packet_lost;
    logic retransmit;
    logic new_packet;
  } radio_events_t;

endpackage

/* rtl/spi_shift_slave.sv */
`timescale 1ns/1ps
`include "radio_regs_map.svh"

module spi_shift_slave (
  input  wire logic       mclk_i,
  input  wire logic       rst_n_i,
  input  wire logic       ce_i,
  input  wire logic       sck_i,
  input  wire logic       csn_i,
  input  wire logic       mosi_i,
  input  wire logic [7:0] status_i,
  input  wire logic [7:0] tx_byte_i,
  output logic            frame_start_o,
  output logic            byte_done_o,
  output logic [7:0]      rx_byte_o,
  output logic            miso_o,
  output logic            miso_oe_o
);

  logic [1:0] sck_s;
  logic [1:0] csn_s;
  logic [1:0] mosi_s;
  logic       sck_d;
  logic       csn_d;
  logic [2:0] bit_cnt_q;
  logic [6:0] rx_sh_q;
  logic [7:0] tx_sh_q;
  logic       active;
  logic       rise;
  logic       fall;
  logic       start;

  assign active = ~csn_s[1];
  assign rise   = sck_s[1] & ~sck_d;
  assign fall   = ~sck_s[1] & sck_d;
  assign start  = ~csn_s[1] & csn_d;

  // Pins are asynchronous to mclk; two stages before any use
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sck_s  <= 2'h0;
      csn_s  <= 2'h3;
      mosi_s <= 2'h0;
      sck_d  <= 1'b0;
      csn_d  <= 1'b1;
    end else if (ce_i) begin
      sck_s  <= {sck_s[0], sck_i};
      csn_s  <= {csn_s[0], csn_i};
      mosi_s <= {mosi_s[0], mosi_i};
      sck_d  <= sck_s[1];
      csn_d  <= csn_s[1];
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      bit_cnt_q     <= 3'h0;
      rx_sh_q       <= 7'h00;
      rx_byte_o     <= 8'h00;
      byte_done_o   <= 1'b0;
      frame_start_o <= 1'b0;
    end else if (ce_i) begin
      byte_done_o   <= 1'b0;
      frame_start_o <= start;
      if (!active) begin
        bit_cnt_q <= 3'h0;
      end else if (rise) begin
        rx_sh_q   <= {rx_sh_q[5:0], mosi_s[1]};
        bit_cnt_q <= bit_cnt_q + 3'h1;
        if (bit_cnt_q == `SPI_LAST_BIT) begin
          rx_byte_o   <= {rx_sh_q, mosi_s[1]};
          byte_done_o <= 1'b1;
        end
      end
    end
  end

  // Status goes out in parallel with the command byte
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tx_sh_q   <= 8'h00;
      miso_o    <= 1'b0;
      miso_oe_o <= 1'b0;
    end else if (ce_i) begin
      if (start) begin
        tx_sh_q <= status_i;
      end else if (byte_done_o) begin
        tx_sh_q <= tx_byte_i;
      end else if (active && fall && bit_cnt_q != 3'h0) begin
        tx_sh_q <= {tx_sh_q[6:0], 1'b0};
      end
      miso_o    <= tx_sh_q[7];
      miso_oe_o <= active;
    end
  end

endmodule // spi_shift_slave

/* rtl/tx_observe_counters.sv */
`timescale 1ns/1ps

module tx_observe_counters #(
  parameter int CNT_W = 4
) (
  input  wire logic             mclk_i,
  input  wire logic             rst_n_i,
  input  wire logic             ce_i,
  input  wire logic             packet_lost_i,
  input  wire logic             lost_clear_i,
  input  wire logic             retransmit_i,
  input  wire logic             new_packet_i,
  output logic [CNT_W-1:0]      lost_cnt_o,
  output logic [CNT_W-1:0]      retx_cnt_o
);

  localparam logic [CNT_W-1:0] CNT_MAX = '1;
  localparam logic [CNT_W-1:0] CNT_ONE = CNT_W'(1);

  // Saturates at all-ones; a loss in the clearing cycle still counts
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      lost_cnt_o <= '0;
    end else if (ce_i) begin
      if (lost_clear_i) begin
        lost_cnt_o <= packet_lost_i ? CNT_ONE : '0;
      end else if (packet_lost_i && lost_cnt_o != CNT_MAX) begin
        lost_cnt_o <= lost_cnt_o + CNT_ONE;
      end
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      retx_cnt_o <= '0;
    end else if (ce_i) begin
      if (new_packet_i) begin
        retx_cnt_o <= '0;
      end else if (retransmit_i && retx_cnt_o != CNT_MAX) begin
        retx_cnt_o <= retx_cnt_o + CNT_ONE;
      end
    end
  end

endmodule // tx_observe_counters

/* tb/radio_status_address_regs_monitor.sv */
`timescale 1ns/1ps
module radio_status_address_regs_monitor (
  input wire logic                          mclk_i,
  input wire logic                          rst_n_i,
  input wire logic                          csn_i,
  input wire logic                          miso_oe_o,
  input wire logic                          comm_blocked_o,
  input wire logic                          channel_write_o,
  input wire radio_regs_pkg::radio_events_t events_i,
  input wire logic [1:0]                    address_width_field_i,
  input wire logic [39:0]                   pipe0_addr_o,
  input wire logic [39:0]                   pipe1_addr_o,
  input wire logic [39:0]                   pipe2_addr_o,
  input wire logic [39:0]                   pipe3_addr_o
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);
  chk_limit_blocks_link: assert property (events_i.retx_limit_hit |-> ##2 comm_blocked_o)
    else $error("link not blocked after limit event");
  // Only a host write can clear the flag, so the drop lands inside a frame
  chk_clear_in_frame: assert property ($fell(comm_blocked_o) |-> !csn_i)
    else $error("block dropped outside a frame");
  chk_upper_from_pipe1: assert property (pipe2_addr_o[39:8] == pipe1_addr_o[39:8] &&
    pipe3_addr_o[39:8] == pipe1_addr_o[39:8])
    else $error("pipe 2 or 3 upper bytes differ from pipe 1");
  chk_width3_mask: assert property (address_width_field_i == 2'h1 &&
    $past(address_width_field_i) == 2'h1 |-> pipe0_addr_o[39:24] == 16'h0000)
    else $error("pipe 0 bytes above width three not zero");
  chk_width4_mask: assert property (address_width_field_i == 2'h2 &&
    $past(address_width_field_i) == 2'h2 |-> pipe1_addr_o[39:32] == 8'h00)
    else $error("pipe 1 byte above width four not zero");
  chk_frame_drives_out: assert property ($fell(csn_i) |-> ##[1:6] miso_oe_o)
    else $error("serial output not enabled in frame");
  chk_idle_releases: assert property (csn_i [*6] |-> !miso_oe_o)
    else $error("serial output driven while deselected");
  chk_channel_pulse: assert property (channel_write_o |-> !csn_i ##1 !channel_write_o)
    else $error("channel write strobe not a single in-frame pulse");
endmodule // radio_status_address_regs_monitor

bind radio_status_address_regs radio_status_address_regs_monitor u_radio_status_address_regs_monitor (
  .mclk_i(mclk_i), .rst_n_i(rst_n_i), .csn_i(csn_i), .miso_oe_o(miso_oe_o),
  .comm_blocked_o(comm_blocked_o), .channel_write_o(channel_write_o), .events_i(events_i),
  .address_width_field_i(address_width_field_i), .pipe0_addr_o(pipe0_addr_o),
  .pipe1_addr_o(pipe1_addr_o), .pipe2_addr_o(pipe2_addr_o), .pipe3_addr_o(pipe3_addr_o)
);

/* tb/spi_host_model.sv */
`timescale 1ns/1ps
module spi_host_model (
  input  wire logic mclk_i,
  input  wire logic miso_i,
  output logic      sck_o,
  output logic      csn_o,
  output logic      mosi_o
);
  initial begin
    sck_o = 1'b0;
    csn_o = 1'b1;
    mosi_o = 1'b0;
  end
  // Half period of 8 cycles keeps sck well below the mclk/8 limit
  task automatic frame(input logic [7:0] tx [$], output logic [7:0] rx [$]);
    logic [7:0] b;
    rx = {};
    @(posedge mclk_i) csn_o <= 1'b0;
    repeat (8) @(posedge mclk_i);
    foreach (tx[i]) begin
      for (int k = 7; k >= 0; k--) begin
        mosi_o <= tx[i][k];
        repeat (8) @(posedge mclk_i);
        sck_o <= 1'b1;
        b[k] = miso_i;
        repeat (8) @(posedge mclk_i);
        sck_o <= 1'b0;
      end
      rx.push_back(b);
    end
    repeat (8) @(posedge mclk_i);
    csn_o <= 1'b1;
    // Released data line must not keep its last bit
    mosi_o <= ~mosi_o;
    repeat (12) @(posedge mclk_i);
  endtask
endmodule // spi_host_model

/* tb/radio_status_address_regs_test.sv */
`timescale 1ns/1ps
`include "radio_regs_map.svh"
module radio_status_address_regs_test;
  logic                          mclk, rst_n, ce, sck, csn, mosi, miso, miso_oe;
  logic                          ack_en, empty, full, pwr, blocked, chan_wr;
  logic [2:0]                    head;
  logic [1:0]                    aw;
  logic [39:0]                   p0, p1, p2, p3;
  radio_regs_pkg::radio_events_t events;
  int                            n_errors = 0;
  int                            checks = 0;

  radio_status_address_regs u_radio_status_address_regs (
    .mclk_i(mclk), .rst_n_i(rst_n), .ce_i(ce), .sck_i(sck), .csn_i(csn), .mosi_i(mosi),
    .miso_o(miso), .miso_oe_o(miso_oe), .events_i(events), .auto_ack_en_i(ack_en),
    .rx_head_pipe_i(head), .rx_empty_i(empty), .tx_full_i(full), .power_detect_i(pwr),
    .address_width_field_i(aw), .comm_blocked_o(blocked), .channel_write_o(chan_wr),
    .pipe0_addr_o(p0), .pipe1_addr_o(p1), .pipe2_addr_o(p2), .pipe3_addr_o(p3)
  );
  spi_host_model u_spi_host_model (
    .mclk_i(mclk), .miso_i(miso), .sck_o(sck), .csn_o(csn), .mosi_o(mosi)
  );

  task automatic end_sim();
    if (n_errors == 0 && checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic check(input string nm, input logic [39:0] exp, input logic [39:0] got);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic pulse(input logic [6:0] ev, input int n);
    repeat (n) begin
      @(posedge mclk) events <= ev;
      @(posedge mclk) events <= 7'h00;
    end
  endtask
  task automatic rd(input logic [4:0] a, input int n, output logic [7:0] r [$]);
    logic [7:0] d [$];
    repeat (n) d.push_back(8'h00);
    d.push_front({`CMD_OP_READ, a});
    u_spi_host_model.frame(d, r);
  endtask
  // Address bytes go least significant first
  task automatic wr(input logic [4:0] a, input logic [7:0] d [$]);
    logic [7:0] r [$];
    d.push_front({`CMD_OP_WRITE, a});
    u_spi_host_model.frame(d, r);
  endtask
  // Status comes back beside the command byte of any frame
  task automatic stat(input logic [7:0] exp);
    logic [7:0] r [$];
    rd(`REG_STATUS, 0, r);
    check("status", exp, r[0]);
  endtask
  task automatic reg8(input logic [4:0] a, input logic [7:0] exp);
    logic [7:0] r [$];
    rd(a, 1, r);
    check($sformatf("reg %h", a), exp, r[1]);
  endtask

  task automatic t_reset();
    logic [7:0] r [$];
    check("p2_out", 40'hC2C2C2C2C3, p2);
    check("p3_out", 40'hC2C2C2C2C4, p3);
    check("p0_out", 40'hE7E7E7E7E7, p0);
    stat(8'h0E);
    rd(`REG_PIPE0_ADDR, 5, r);
    check("p0_rst", 40'hE7E7E7E7E7, {r[5], r[4], r[3], r[2], r[1]});
    reg8(`REG_PIPE2_LOW, 8'hC3);
  endtask
  task automatic t_flags();
    empty <= 1'b0;
    head <= 3'h5;
    full <= 1'b1;
    pulse(7'h68, 1);
    stat(8'h7B);
    check("blocked", 1'b1, blocked);
    wr(`REG_STATUS, '{8'h0F});
    stat(8'h7B);
    wr(`REG_STATUS, '{8'h70});
    stat(8'h0B);
    check("blocked", 1'b0, blocked);
  endtask
  task automatic t_ack();
    ack_en <= 1'b1;
    pulse(7'h20, 1);
    stat(8'h0B);
    pulse(7'h10, 1);
    stat(8'h2B);
    wr(`REG_STATUS, '{8'h20});
    empty <= 1'b1;
    full <= 1'b0;
    stat(8'h0E);
  endtask
  task automatic t_count();
    pulse(7'h04, 17);
    pulse(7'h02, 3);
    reg8(`REG_OBSERVE, 8'hF3);
    pulse(7'h01, 1);
    wr(`REG_OBSERVE, '{8'h55});
    reg8(`REG_OBSERVE, 8'hF0);
    wr(`REG_CHANNEL_SELECT, '{8'h02});
    reg8(`REG_OBSERVE, 8'h00);
  endtask
  task automatic t_pwr();
    pwr <= 1'b1;
    reg8(`REG_POWER_DETECT, 8'h01);
    wr(`REG_POWER_DETECT, '{8'hFE});
    reg8(`REG_POWER_DETECT, 8'h01);
    pwr <= 1'b0;
    reg8(`REG_POWER_DETECT, 8'h00);
  endtask
  // Enable low must hold the rx_ready flag still
  task automatic t_freeze();
    ce <= 1'b0;
    pulse(7'h40, 1);
    ce <= 1'b1;
    stat(8'h0E);
    pulse(7'h40, 1);
    stat(8'h4E);
    wr(`REG_STATUS, '{8'h40});
    stat(8'h0E);
  endtask
  task automatic t_addr();
    logic [7:0]  r [$];
    logic [39:0] m;
    wr(`REG_PIPE1_ADDR, '{8'h11, 8'h22, 8'h33, 8'h44, 8'h55});
    wr(`REG_PIPE2_LOW, '{8'hA0});
    rd(`REG_PIPE1_ADDR, 5, r);
    check("p1_read", 40'h5544332211, {r[5], r[4], r[3], r[2], r[1]});
    check("p2_out", 40'h55443322A0, p2);
    for (int c = 1; c < 4; c++) begin
      aw <= c[1:0];
      repeat (3) @(posedge mclk);
      m = (40'h01 << (8 * (c + 2))) - 40'h01;
      check("p1_out", 40'h5544332211 & m, p1);
      check("p3_out", 40'h55443322C4 & m, p3);
    end
    // Bytes beyond a three-byte width must not land
    aw <= 2'h1;
    wr(`REG_PIPE0_ADDR, '{8'h01, 8'h02, 8'h03, 8'h04, 8'h05});
    rd(`REG_PIPE0_ADDR, 5, r);
    check("p0_width3", 40'hE7E7030201, {r[5], r[4], r[3], r[2], r[1]});
    check("p0_out", 40'h0000030201, p0);
  endtask

  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end
  initial begin
    repeat (60000) @(posedge mclk);
    n_errors++;
    end_sim();
  end
  initial begin
    rst_n = 1'b0;
    ce = 1'b1;
    events = 7'h00;
    ack_en = 1'b0;
    head = 3'h0;
    empty = 1'b1;
    full = 1'b0;
    pwr = 1'b0;
    aw = 2'h3;
    repeat (6) @(posedge mclk);
    rst_n <= 1'b1;
    repeat (3) @(posedge mclk);
    t_reset();
    t_flags();
    t_ack();
    t_count();
    t_pwr();
    t_freeze();
    t_addr();
    end_sim();
  end
endmodule // radio_status_address_regs_test
